// File: rtl/jtc_defines.vh
// Named constants shared by the test access port, its checker and its bench.
// Assumes inclusion by bare name from the controller, the checker and the bench; the synchroniser and FIFO files do not include it.
`ifndef JTC_DEFINES_VH
`define JTC_DEFINES_VH

// ==================================================================
// State machine encodings (sixteen test-port states)
// ==================================================================
`define JTC_ST_RESET       4'hF
`define JTC_ST_IDLE        4'hC
`define JTC_ST_SEL_DR      4'h7
`define JTC_ST_CAP_DR      4'h6
`define JTC_ST_SHIFT_DR    4'h2
`define JTC_ST_EXIT1_DR    4'h1
`define JTC_ST_PAUSE_DR    4'h3
`define JTC_ST_EXIT2_DR    4'h0
`define JTC_ST_UPD_DR      4'h5
`define JTC_ST_SEL_IR      4'h4
`define JTC_ST_CAP_IR      4'hE
`define JTC_ST_SHIFT_IR    4'hA
`define JTC_ST_EXIT1_IR    4'h9
`define JTC_ST_PAUSE_IR    4'hB
`define JTC_ST_EXIT2_IR    4'h8
`define JTC_ST_UPD_IR      4'hD
`define JTC_ST_W           4

// ==================================================================
// Instruction codes and chain widths
// ==================================================================
`define JTC_IR_W           4
`define JTC_IR_EXTEST      4'h0
`define JTC_IR_INTEST      4'h1
`define JTC_IR_SAMPLE      4'h2
`define JTC_IR_DBG_ABORT   4'h8
`define JTC_IR_DBG_DPACC   4'hA
`define JTC_IR_DBG_APACC   4'hB
`define JTC_IR_IDCODE      4'hE
`define JTC_IR_BYPASS      4'hF
`define JTC_IR_CAPTURE     4'h1
`define JTC_ID_W           32
// Identification value is arbitrary and names no real part.
`define JTC_ID_VALUE       32'h0000_0001
`define JTC_BSR_W          8
`define JTC_ID_MSB         31
`define JTC_BSR_MSB        7
`define JTC_IR_MSB         3

// ==================================================================
// Pin function selection and buffering
// ==================================================================
`define JTC_PIN_N          5
`define JTC_ALT_FUNCTION_SELECT_BIT_RESET    5'h1F
`define JTC_ALT_FUNCTION_SELECT_BIT_TDO      4
`define JTC_FIFO_DEPTH     4
`define JTC_PIN_RESET      4'hF

`endif

// File: rtl/jtc_sync.v
// Two-stage synchroniser for a group of pin inputs.
// Assumes the inputs are asynchronous to clock; reset forces the pulled-up level.
`timescale 1ns/1ps
`default_nettype none

module jtc_sync #(
   parameter WIDTH     = 4,
   parameter RESET_VAL = 4'hF
) (
   input  wire             clock,    // System clock.
   input  wire             rst_n,    // Synchronous reset, active low.
   input  wire [WIDTH-1:0] async_in, // Raw pin levels.
   output wire [WIDTH-1:0] sync_out  // Levels after two flip-flops.
);

   reg [WIDTH-1:0] stage1;
   reg [WIDTH-1:0] stage2;

   // ==================================================================
   // Per-bit flop pairs
   // ==================================================================
   // The first stage feeds only the second, so metastability never reaches logic.
   genvar i;
   generate
      for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
         always @(posedge clock) begin
            if (!rst_n) begin
               stage1[i] <= RESET_VAL[i];
               stage2[i] <= RESET_VAL[i];
            end else begin
               stage1[i] <= async_in[i];
               stage2[i] <= stage1[i];
            end
         end
      end
   endgenerate

   assign sync_out = stage2;

endmodule

`default_nettype wire

// File: rtl/jtc_fifo.v
// Small synchronous FIFO with valid and ready on both sides.
// Assumes one clock; flags are held in flip-flops so in_ready and out_valid are registered.
`timescale 1ns/1ps
`default_nettype none

module jtc_fifo #(
   parameter WIDTH = 8,
   parameter DEPTH = 4,
   parameter AW    = 2
) (
   input  wire             clock,     // System clock.
   input  wire             rst_n,     // Synchronous reset, active low.
   input  wire             in_valid,  // Word offered.
   output wire             in_ready,  // Room for a word.
   input  wire [WIDTH-1:0] in_data,   // Word to store.
   output wire             out_valid, // Word available.
   input  wire             out_ready, // Consumer takes the word.
   output wire [WIDTH-1:0] out_data   // Oldest word.
);

   reg [WIDTH-1:0] mem [0:DEPTH-1];
   reg [AW-1:0]    wr_ptr;
   reg [AW-1:0]    rd_ptr;
   reg [AW:0]      count;
   reg             full;
   reg             empty;
   wire            push;
   wire            pop;
   reg [AW:0]      next_count;

   assign push      = in_valid & ~full;
   assign pop       = out_ready & ~empty;
   assign in_ready  = ~full;
   assign out_valid = ~empty;
   assign out_data  = mem[rd_ptr];

   // ==================================================================
   // Occupancy
   // ==================================================================
   always @* begin
      next_count = count;
      if (push && !pop) begin
         next_count = count + 1'b1;
      end else if (pop && !push) begin
         next_count = count - 1'b1;
      end
   end

   // Pointers, storage and registered flags.
   always @(posedge clock) begin
      if (!rst_n) begin
         wr_ptr <= {AW{1'b0}};
         rd_ptr <= {AW{1'b0}};
         count  <= {(AW+1){1'b0}};
         full   <= 1'b0;
         empty  <= 1'b1;
      end else begin
         if (push) begin
            mem[wr_ptr] <= in_data;
            wr_ptr      <= wr_ptr + 1'b1;
         end
         if (pop) begin
            rd_ptr <= rd_ptr + 1'b1;
         end
         count <= next_count;
         full  <= (next_count == DEPTH[AW:0]);
         empty <= (next_count == {(AW+1){1'b0}});
      end
   end

endmodule

`default_nettype wire

// File: rtl/jtc_tap.v
// Test access port controller: state machine, instruction chain, data chains.
// Assumes the test pins arrive asynchronously and are oversampled by clock,
// which must run several times faster than the test clock.
//
// Contract
// - State advances only on test-clock rising edges.
// - Current state picks chain and capture/shift/update.
// - Held instruction selects the data chain.
// - External/internal test instructions touch no chain.
// - Unimplemented instruction codes act as bypass.
// - Test reset low forces and holds reset state.
// - Power-on reset also forces reset state.
// - Entering reset state loads identification instruction.
// - Five mode-select highs reach reset state.
// - Stopped test clock keeps state and data.
// - Data input sampled on rising edge into chain.
// - Data output undriven unless shifting; off after reset.
// - Capture loads chain; shift moves one bit.
// - Update copies chain to parallel register; a boundary update also pushes the word into the buffer.
// - Pins default to debug function; software reassigns.
// - Four-bit instruction chain, decoded parallel register.
// - Code 1111 is bypass, 1110 is identification.
// - Output muxed to core debug port by instruction.
`include "jtc_defines.vh"
`timescale 1ns/1ps
`default_nettype none

module jtc_tap (
   input  wire                  clock,           // System clock, 250 MHz.
   input  wire                  rst_n,           // Power-on reset, synchronous, active low.
   input  wire                  tck_pin,         // Test clock pin.
   input  wire                  tms_pin,         // Mode-select pin.
   input  wire                  tdi_pin,         // Serial data input pin.
   input  wire                  trst_n_pin,      // Test reset pin, active low.
   output reg                   tdo_out,         // Serial data output level.
   output reg                   tdo_oe_n,        // Output enable, low while driving.
   input  wire                  core_tdo,        // Serial output of the core debug port.
   output reg                   core_select,     // High while a core debug code is held.
   output reg  [`JTC_ST_W-1:0]  tap_state,       // Current state machine state.
   output reg  [`JTC_IR_W-1:0]  instruction,     // Decoded parallel instruction.
   input  wire [`JTC_BSR_W-1:0] pad_in,          // Pad levels captured by sampling.
   output reg  [`JTC_BSR_W-1:0] bsr_out,         // Boundary parallel register.
   output reg                   extest_active,   // Drive boundary values onto pads.
   output reg                   intest_active,   // Drive boundary values into the core.
   input  wire                  alt_function_select_bit_wr,        // Software write strobe for selects.
   input  wire [`JTC_PIN_N-1:0] alt_function_select_bit_data,      // New select bits, one per pin.
   output reg  [`JTC_PIN_N-1:0] alt_function_select_reg, // Debug function select per pin.
   output wire                  upd_valid,       // Boundary update word available.
   input  wire                  upd_ready,       // Consumer takes the word.
   output wire [`JTC_BSR_W-1:0] upd_data,        // Oldest boundary update word.
   output reg                   upd_fifo_ready   // Registered room flag of the buffer.
);

   // ==================================================================
   // Declarations
   // ==================================================================
   wire [3:0]            pin_sync;
   wire                  s_tck;
   wire                  s_tms;
   wire                  s_tdi;
   wire                  s_trst_n;
   reg                   tck_prev;
   wire                  tck_rise;
   wire                  tck_fall;
   reg [`JTC_IR_W-1:0]   ir_shift;
   reg                   bypass_bit;
   reg [`JTC_ID_W-1:0]   id_shift;
   reg [`JTC_BSR_W-1:0]  bsr_shift;
   reg [`JTC_ST_W-1:0]   next_state;
   reg                   own_serial;
   reg                   dr_chain_on;
   reg                   upd_push;
   wire                  fifo_in_ready;

   // ==================================================================
   // Functions
   // ==================================================================
   // Standard transition table of the test-port state machine.
   function [`JTC_ST_W-1:0] tap_next;
      input [`JTC_ST_W-1:0] st;
      input                 tms;
      begin
         case (st)
            `JTC_ST_RESET:    tap_next = tms ? `JTC_ST_RESET   : `JTC_ST_IDLE;
            `JTC_ST_IDLE:     tap_next = tms ? `JTC_ST_SEL_DR  : `JTC_ST_IDLE;
            `JTC_ST_SEL_DR:   tap_next = tms ? `JTC_ST_SEL_IR  : `JTC_ST_CAP_DR;
            `JTC_ST_CAP_DR:   tap_next = tms ? `JTC_ST_EXIT1_DR : `JTC_ST_SHIFT_DR;
            `JTC_ST_SHIFT_DR: tap_next = tms ? `JTC_ST_EXIT1_DR : `JTC_ST_SHIFT_DR;
            `JTC_ST_EXIT1_DR: tap_next = tms ? `JTC_ST_UPD_DR  : `JTC_ST_PAUSE_DR;
            `JTC_ST_PAUSE_DR: tap_next = tms ? `JTC_ST_EXIT2_DR : `JTC_ST_PAUSE_DR;
            `JTC_ST_EXIT2_DR: tap_next = tms ? `JTC_ST_UPD_DR  : `JTC_ST_SHIFT_DR;
            `JTC_ST_UPD_DR:   tap_next = tms ? `JTC_ST_SEL_DR  : `JTC_ST_IDLE;
            `JTC_ST_SEL_IR:   tap_next = tms ? `JTC_ST_RESET   : `JTC_ST_CAP_IR;
            `JTC_ST_CAP_IR:   tap_next = tms ? `JTC_ST_EXIT1_IR : `JTC_ST_SHIFT_IR;
            `JTC_ST_SHIFT_IR: tap_next = tms ? `JTC_ST_EXIT1_IR : `JTC_ST_SHIFT_IR;
            `JTC_ST_EXIT1_IR: tap_next = tms ? `JTC_ST_UPD_IR  : `JTC_ST_PAUSE_IR;
            `JTC_ST_PAUSE_IR: tap_next = tms ? `JTC_ST_EXIT2_IR : `JTC_ST_PAUSE_IR;
            `JTC_ST_EXIT2_IR: tap_next = tms ? `JTC_ST_UPD_IR  : `JTC_ST_SHIFT_IR;
            `JTC_ST_UPD_IR:   tap_next = tms ? `JTC_ST_SEL_DR  : `JTC_ST_IDLE;
            default:          tap_next = `JTC_ST_RESET;
         endcase
      end
   endfunction

   // Folds every unimplemented code onto bypass so each such code still has a serial path.
   function [`JTC_IR_W-1:0] ir_decode;
      input [`JTC_IR_W-1:0] code;
      begin
         case (code)
            `JTC_IR_EXTEST, `JTC_IR_INTEST, `JTC_IR_SAMPLE,
            `JTC_IR_DBG_ABORT, `JTC_IR_DBG_DPACC, `JTC_IR_DBG_APACC,
            `JTC_IR_IDCODE:  ir_decode = code;
            default:         ir_decode = `JTC_IR_BYPASS;
         endcase
      end
   endfunction

   // True for codes whose data chain lives in the core debug port.
   function is_core_code;
      input [`JTC_IR_W-1:0] code;
      begin
         is_core_code = (code == `JTC_IR_DBG_ABORT) ||
                        (code == `JTC_IR_DBG_DPACC) ||
                        (code == `JTC_IR_DBG_APACC);
      end
   endfunction

   // ==================================================================
   // Pin synchronisers and test-clock edge detection
   // ==================================================================
   // Pins idle at their pulled-up level, so reset loads ones into the stages.
   jtc_sync #(
      .WIDTH     (4),
      .RESET_VAL (`JTC_PIN_RESET)
   ) u_sync (
      .clock    (clock),
      .rst_n    (rst_n),
      .async_in ({trst_n_pin, tdi_pin, tms_pin, tck_pin}),
      .sync_out (pin_sync)
   );

   assign s_tck    = pin_sync[0];
   assign s_tms    = pin_sync[1];
   assign s_tdi    = pin_sync[2];
   assign s_trst_n = pin_sync[3];

   // Edges are found on the synchronised level; a held clock yields none.
   always @(posedge clock) begin
      if (!rst_n) begin
         tck_prev <= 1'b1;
      end else begin
         tck_prev <= s_tck;
      end
   end

   assign tck_rise = s_tck & ~tck_prev;
   assign tck_fall = ~s_tck & tck_prev;

   // ==================================================================
   // State machine
   // ==================================================================
   // Only a rising edge moves the state; otherwise it holds indefinitely.
   always @* begin
      next_state = tap_state;
      if (tck_rise) begin
         next_state = tap_next(tap_state, s_tms);
      end
   end

   // Test reset is seen through the synchroniser, so it acts a few system
   // cycles after the pin falls; it needs no test-clock edge to act.
   always @(posedge clock) begin
      if (!rst_n) begin
         tap_state <= `JTC_ST_RESET;
      end else if (!s_trst_n) begin
         tap_state <= `JTC_ST_RESET;
      end else begin
         tap_state <= next_state;
      end
   end

   // ==================================================================
   // Instruction chain and parallel instruction register
   // ==================================================================
   always @(posedge clock) begin
      if (!rst_n) begin
         ir_shift    <= `JTC_IR_CAPTURE;
         instruction <= `JTC_IR_IDCODE;
      end else if (!s_trst_n || tap_state == `JTC_ST_RESET) begin
         instruction <= `JTC_IR_IDCODE;
      end else if (tck_rise) begin
         case (tap_state)
            `JTC_ST_CAP_IR: begin
               ir_shift <= `JTC_IR_CAPTURE;
            end
            `JTC_ST_SHIFT_IR: begin
               ir_shift <= {s_tdi, ir_shift[`JTC_IR_MSB:1]};
            end
            `JTC_ST_UPD_IR: begin
               instruction <= ir_decode(ir_shift);
            end
            default: begin
               ir_shift <= ir_shift;
            end
         endcase
      end
   end

   // ==================================================================
   // Data chains
   // ==================================================================
   // Test instructions leave every data chain alone; they only use bsr_out.
   always @(posedge clock) begin
      if (!rst_n) begin
         bypass_bit <= 1'b0;
         id_shift   <= `JTC_ID_VALUE;
         bsr_shift  <= {`JTC_BSR_W{1'b0}};
         bsr_out    <= {`JTC_BSR_W{1'b0}};
         upd_push   <= 1'b0;
      end else begin
         upd_push <= 1'b0;
         if (tck_rise && s_trst_n) begin
            case (instruction)
               `JTC_IR_SAMPLE: begin
                  if (tap_state == `JTC_ST_CAP_DR) begin
                     bsr_shift <= pad_in;
                  end else if (tap_state == `JTC_ST_SHIFT_DR) begin
                     bsr_shift <= {s_tdi, bsr_shift[`JTC_BSR_MSB:1]};
                  end else if (tap_state == `JTC_ST_UPD_DR) begin
                     bsr_out  <= bsr_shift;
                     upd_push <= 1'b1;
                  end
               end
               `JTC_IR_IDCODE: begin
                  if (tap_state == `JTC_ST_CAP_DR) begin
                     id_shift <= `JTC_ID_VALUE;
                  end else if (tap_state == `JTC_ST_SHIFT_DR) begin
                     id_shift <= {s_tdi, id_shift[`JTC_ID_MSB:1]};
                  end
               end
               `JTC_IR_BYPASS: begin
                  if (tap_state == `JTC_ST_CAP_DR) begin
                     bypass_bit <= 1'b0;
                  end else if (tap_state == `JTC_ST_SHIFT_DR) begin
                     bypass_bit <= s_tdi;
                  end
               end
               default: begin
                  bypass_bit <= bypass_bit;
               end
            endcase
         end
      end
   end

   // ==================================================================
   // Serial output selection
   // ==================================================================
   // Chooses the bit that the addressed chain presents at its output end.
   always @* begin
      own_serial  = bypass_bit;
      dr_chain_on = 1'b1;
      case (instruction)
         `JTC_IR_SAMPLE:  own_serial = bsr_shift[0];
         `JTC_IR_IDCODE:  own_serial = id_shift[0];
         `JTC_IR_EXTEST,
         `JTC_IR_INTEST:  dr_chain_on = 1'b0;
         default:         own_serial = bypass_bit;
      endcase
      if (tap_state == `JTC_ST_SHIFT_IR) begin
         own_serial  = ir_shift[0];
         dr_chain_on = 1'b1;
      end
   end

   // Output changes on falling edges so a downstream part samples it settled.
   // The driver is released outside shift states to save pad power.
   always @(posedge clock) begin
      if (!rst_n) begin
         tdo_out     <= 1'b1;
         tdo_oe_n    <= 1'b1;
         core_select <= 1'b0;
      end else begin
         core_select <= is_core_code(instruction);
         if (!s_trst_n || tap_state == `JTC_ST_RESET) begin
            tdo_oe_n <= 1'b1;
         end else if (tck_fall) begin
            if (is_core_code(instruction) && tap_state == `JTC_ST_SHIFT_DR) begin
               tdo_out <= core_tdo;
            end else begin
               tdo_out <= own_serial;
            end
            tdo_oe_n <= ~(((tap_state == `JTC_ST_SHIFT_DR) && dr_chain_on) ||
                          (tap_state == `JTC_ST_SHIFT_IR)) ||
                        ~alt_function_select_reg[`JTC_ALT_FUNCTION_SELECT_BIT_TDO];
         end
      end
   end

   // ==================================================================
   // Test status outputs
   // ==================================================================
   // Both test modes only steer from the held boundary register: extest onto the pads, intest into the core.
   always @(posedge clock) begin
      if (!rst_n) begin
         extest_active <= 1'b0;
         intest_active <= 1'b0;
      end else begin
         extest_active <= (instruction == `JTC_IR_EXTEST);
         intest_active <= (instruction == `JTC_IR_INTEST);
      end
   end

   // ==================================================================
   // Pin function selection
   // ==================================================================
   // Reset gives every pin its debug role; an early software write to zero
   // can lock a probe out, which is the user's responsibility.
   always @(posedge clock) begin
      if (!rst_n) begin
         alt_function_select_reg <= `JTC_ALT_FUNCTION_SELECT_BIT_RESET;
      end else if (alt_function_select_bit_wr) begin
         alt_function_select_reg <= alt_function_select_bit_data;
      end
   end

   // ==================================================================
   // Boundary update buffer
   // ==================================================================
   // The test clock cannot be stalled, so a word pushed into a full buffer is
   // dropped; the registered room flag lets the consumer see that coming.
   jtc_fifo #(
      .WIDTH (`JTC_BSR_W),
      .DEPTH (`JTC_FIFO_DEPTH),
      .AW    (2)
   ) u_fifo (
      .clock     (clock),
      .rst_n     (rst_n),
      .in_valid  (upd_push),
      .in_ready  (fifo_in_ready),
      .in_data   (bsr_out),
      .out_valid (upd_valid),
      .out_ready (upd_ready),
      .out_data  (upd_data)
   );

   // Room flag is registered so the port comes from a flip-flop.
   always @(posedge clock) begin
      if (!rst_n) begin
         upd_fifo_ready <= 1'b0;
      end else begin
         upd_fifo_ready <= fifo_in_ready;
      end
   end

endmodule

`default_nettype wire

// File: tb/jtc_tap_checker.sv
// Assertions on the test access port, seen at its ports.
// Assumes test pin phases last at least eight system clocks.
`include "jtc_defines.vh"
`timescale 1ns/1ps
`default_nettype none
module jtc_tap_checker (
   input wire logic       clock, // Clock.
   input wire logic       rst_n, // Reset.
   input wire logic       tck_pin, // Test clock.
   input wire logic       trst_n_pin, // Test reset.
   input wire logic       tdo_out, // Data out.
   input wire logic       tdo_oe_n, // Drive enable.
   input wire logic [3:0] tap_state, // State.
   input wire logic [3:0] instruction, // Instruction.
   input wire logic [7:0] bsr_out, // Boundary.
   input wire logic       extest_active, // Pad drive.
   input wire logic       intest_active, // Core drive.
   input wire logic [4:0] alt_function_select_reg, // Selects.
   input wire logic       upd_valid, // Word ready.
   input wire logic       upd_ready, // Pop.
   input wire logic [7:0] upd_data // Head word.
);
   // ==========================================
   // Properties on the system clock
   default clocking @(posedge clock); endclocking
   default disable iff (!rst_n);
   // Only shift states may drive the output.
   wire logic shifting = tap_state == `JTC_ST_SHIFT_DR || tap_state == `JTC_ST_SHIFT_IR;
   a_trst_forces: assert property (!trst_n_pin [*4] |-> tap_state == `JTC_ST_RESET)
      else $error("reset state not forced");
   a_still_clock: assert property (($stable(tck_pin) && trst_n_pin) [*8] |->
      $stable(tap_state) && $stable(instruction)) else $error("state moved without clock");
   a_tdo_fall: assert property ($changed(tdo_out) |-> !$past(tck_pin))
      else $error("data out moved in clock high");
   a_oe_shift: assert property ($fell(tdo_oe_n) |-> shifting && alt_function_select_reg[4]
      && !(tap_state == `JTC_ST_SHIFT_DR && (extest_active || intest_active)))
      else $error("output driven outside shift");
   a_oe_release: assert property (!tdo_oe_n && !shifting |-> ##[1:16] tdo_oe_n)
      else $error("output not released");
   a_test_hold: assert property ((extest_active || intest_active) && $stable(instruction)
      |-> $stable(bsr_out)) else $error("boundary moved in test mode");
   a_fifo_hold: assert property (upd_valid && !upd_ready |=> upd_valid && $stable(upd_data))
      else $error("buffer head lost");
   a_known_code: assert property (instruction inside {4'h0, 4'h1, 4'h2, 4'h8, 4'hA, 4'hB,
      4'hE, 4'hF}) else $error("unknown code held");
   cover property (tap_state == `JTC_ST_SHIFT_IR && !tdo_oe_n);
   cover property (!trst_n_pin [*4]);
   cover property (upd_valid && !upd_ready);
endmodule
bind jtc_tap jtc_tap_checker jtc_tap_checker_i (.*);
`default_nettype wire

// File: tb/jtc_probe.sv
// Probe model: drives the test pins and reads the serial output.
// Assumes the output line is pulled up whenever the port releases it.
`timescale 1ns/1ps
`default_nettype none
module jtc_probe (
   output var logic  tck_pin,    // Test clock.
   output var logic  tms_pin,    // Mode select.
   output var logic  tdi_pin,    // Data in.
   output var logic  trst_n_pin, // Test reset.
   input  wire logic tdo_out,    // Data out.
   input  wire logic tdo_oe_n    // Low while driven.
);
   // ==========================================
   // Pin cycles
   // Pins idle high, as pulled up; the clock rests low.
   initial {tck_pin, tms_pin, tdi_pin, trst_n_pin} = 4'h7;
   // One period; a released output reads high.
   task tick(input logic m, input logic d, output logic q);
      {tms_pin, tdi_pin} = {m, d};
      #32 q = tdo_oe_n ? 1'b1 : tdo_out;
      tck_pin = 1'b1;
      #32 tck_pin = 1'b0;
   endtask
   // Idle-to-idle scan of n bits, LSB first.
   task scan(input logic ir, input logic [31:0] din, input int n, output logic [31:0] dout);
      logic q;
      dout = '0;
      tick(1'b1, 1'b1, q);
      if (ir) tick(1'b1, 1'b1, q);
      repeat (2) tick(1'b0, 1'b1, q);
      for (int i = 0; i < n; i++) begin
         tick(i == n - 1, din[i], q);
         dout[i] = q;
      end
      tick(1'b1, 1'b1, q);
      tick(1'b0, 1'b1, q);
   endtask
endmodule
`default_nettype wire

// File: tb/tb_top.sv
// Self-checking bench for the test access port with the probe on its pins.
// Assumes the design and the probe model are compiled first.
`include "jtc_defines.vh"
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   logic            clock, rst_n, core_tdo, alt_function_select_bit_wr, upd_ready, q;
   logic [7:0]      pad_in, b;
   logic [4:0]      alt_function_select_bit_data;
   logic [3:0]      e;
   logic [31:0]     seed = 32'ha7d0_e26a, r, d;
   logic [7:0]      fq[$];
   int              n_mismatch = 0, check_count = 0;
   wire logic       tck_pin, tms_pin, tdi_pin, trst_n_pin, tdo_out, tdo_oe_n, core_select;
   wire logic       extest_active, intest_active, upd_valid, upd_fifo_ready;
   wire logic [3:0] tap_state, instruction;
   wire logic [7:0] bsr_out, upd_data;
   wire logic [4:0] alt_function_select_reg;
   jtc_tap   jtc_tap_i (.*);
   jtc_probe jtc_probe_i (.*);
   // ==========================================
   // Clock, helpers and verdict
   initial begin
      clock = 1'b0;
      forever #2 clock = ~clock;
   end
   function logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   // Unimplemented codes act as bypass.
   function logic [3:0] exp_ir(input logic [3:0] c);
      return (c inside {[4'h0:4'h2], 4'h8, 4'hA, 4'hB, 4'hE}) ? c : 4'hF;
   endfunction
   task chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
      check_count++;
      if (got !== ex) begin
         n_mismatch++;
         $display("[ERR] %s expected %h seen %h", nm, ex, got);
      end
   endtask
   task results;
      if (n_mismatch == 0 && check_count > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   // Watchdog at about two and a half times the run length.
   initial begin
      #80000 n_mismatch++;
      results;
   end
   // ==========================================
   // Scenarios
   initial begin
      {rst_n, core_tdo, alt_function_select_bit_wr, pad_in, alt_function_select_bit_data, upd_ready} = 17'h0_003F;
      repeat (5) @(posedge clock);
      @(negedge clock) rst_n = 1'b1;
      chk("reset", 14'h3FBF, {tap_state, instruction, tdo_oe_n, alt_function_select_reg});
      jtc_probe_i.tick(1'b0, 1'b1, q);
      jtc_probe_i.scan(1'b0, rnd(), 32, d);
      chk("idcode", `JTC_ID_VALUE, d);
      for (int c = 0; c < 16; c++) begin
         e = exp_ir(c[3:0]);
         jtc_probe_i.scan(1'b1, c, 4, d);
         chk("ir_cap", 4'h1, d);
         chk("instr", {e == 0, e == 1, e inside {4'h8, 4'hA, 4'hB}, e},
            {extest_active, intest_active, core_select, instruction});
         r = rnd();
         @(negedge clock) core_tdo = r[0];
         b = bsr_out;
         jtc_probe_i.scan(1'b0, r, 8, d);
         if (e < 4'h2) chk("quiet", {b, 8'hFF}, {bsr_out, d[7:0]});
         if (e == 4'hF) chk("bypass", {r[6:0], 1'b0}, d);
         if (e inside {4'h8, 4'hA, 4'hB}) chk("core_out", {8{r[0]}}, d);
      end
      jtc_probe_i.tick(1'b1, 1'b1, q);
      repeat (2) jtc_probe_i.tick(1'b0, 1'b1, q);
      repeat (5) jtc_probe_i.tick(1'b1, 1'b1, q);
      chk("tms_reset", 8'hFE, {tap_state, instruction});
      jtc_probe_i.tick(1'b0, 1'b1, q);
      jtc_probe_i.scan(1'b1, 32'h2, 4, d);
      @(negedge clock) upd_ready = 1'b0;
      repeat (5) begin
         r = rnd();
         @(negedge clock) pad_in = r[15:8];
         jtc_probe_i.scan(1'b0, r, 8, d);
         chk("sample", {r[15:0]}, {d[7:0], bsr_out});
         fq.push_back(r[7:0]);
      end
      chk("room", 1'b0, upd_fifo_ready);
      repeat (4) begin
         chk("fifo", fq.pop_front(), upd_data);
         @(negedge clock) upd_ready = 1'b1;
         @(negedge clock) upd_ready = 1'b0;
      end
      @(negedge clock) chk("drained", 2'b01, {upd_valid, upd_fifo_ready});
      repeat (100) @(negedge clock);
      chk("stopped", 8'hC2, {tap_state, instruction});
      jtc_probe_i.trst_n_pin = 1'b0;
      jtc_probe_i.tick(1'b0, 1'b1, q);
      chk("trst", 8'hFE, {tap_state, instruction});
      jtc_probe_i.trst_n_pin = 1'b1;
      @(negedge clock) {alt_function_select_bit_wr, alt_function_select_bit_data} = 6'h2F;
      @(negedge clock) alt_function_select_bit_wr = 1'b0;
      jtc_probe_i.tick(1'b0, 1'b1, q);
      jtc_probe_i.scan(1'b1, 32'hF, 4, d);
      chk("alt_function_select_bit", 9'h1EF, {d[3:0], alt_function_select_reg});
      results;
   end
endmodule
`default_nettype wire
